// ---- hw/pin_function_and_input_level_select.sv ----
/*
 Pin function multiplexer for port A pins 1 and 3, the per-port
 selection register file and the port D input threshold selects.
 Assumes a one-cycle register port on clk, pins synchronised here, and
 a parameter that picks the small or large device variant.
*/
// Notes on behaviour
// [R1] Threshold bit 1 picks the level of port D pins 7..4, bit 0 of pins 3..0.
// [R2] Threshold bits 7..2 read zero and the two used bits reset to zero.
// [R3] A pin's active function comes only from its software selection field.
// [R4] Software selects the pin, then configures, then enables the peripheral.
// [R5] Software sets the port direction to input for inputs sharing the GPIO code.
// [R6] Software disables the peripheral before it reselects the pin.
// [R7] The small variant has port A 0/1, B 0/1, C 0 and F 0, B1 using 3..0, F0 5..0.
// [R8] The large variant adds D 0/1, E 0/1, F 1 and widens B1 to 5..0 and F0 to 8 bits.
// [R9] Small variant pin 3: codes 00..10 give GPIO, 11 key row 1 or LED common 1.
// [R10] Large variant pin 3: 00 GPIO, 01 freq output 0, 10 SPI data in, 11 key row 16.
// [R11] Small variant pin 1: codes 00..10 give GPIO, 11 key row 0 or LED common 0.
// [R12] Large variant pin 1: 00/01 GPIO with timer 0 input, 10 SPI data out, 11 key row 17.
// [R13] Port A register 0 reads bits 5..4 and 1..0 as zero and resets to GPIO.
// [R14] A selected peripheral drives pin value and enable, else the GPIO logic does.
// [R15] A peripheral input whose pin is not selected sits at its inactive level.
`timescale 1ns/1ps
`default_nettype none
module pin_function_and_input_level_select #(
  parameter bit large_variant = 1'b1
) (
  input  wire logic                    clk,
  input  wire logic                    reset,
  input  wire logic [7:0]              addr,
  input  wire logic [7:0]              wdata,
  input  wire logic                    wr_en,
  input  wire logic                    rd_en,
  output logic [7:0]                   rdata,
  input  wire pin_mux_pkg::pin_drive_t gpio_pin1,
  input  wire pin_mux_pkg::pin_drive_t gpio_pin3,
  input  wire pin_mux_pkg::pin_drive_t key_row_0,
  input  wire pin_mux_pkg::pin_drive_t key_row_1,
  input  wire pin_mux_pkg::pin_drive_t key_row_16,
  input  wire pin_mux_pkg::pin_drive_t key_row_17,
  input  wire logic                    freq_output_0,
  input  wire logic                    spi_data_out_pin,
  input  wire logic                    port_a_pin1_in,
  input  wire logic                    port_a_pin3_in,
  output logic                         port_a_pin1_out,
  output logic                         port_a_pin1_oe_n,
  output logic                         port_a_pin3_out,
  output logic                         port_a_pin3_oe_n,
  output pin_mux_pkg::periph_in_t      periph_in,
  output logic                         port_d_upper_level,
  output logic                         port_d_lower_level
);

  // ------------------------------------------------------------------
  // Variant masks
  // ------------------------------------------------------------------
  localparam logic [7:0] mask_pb1 =
    large_variant ? pin_mux_pkg::mask_pb_sel1_lg : pin_mux_pkg::mask_pb_sel1_sm; // R7 R8
  localparam logic [7:0] mask_pf0 =
    large_variant ? pin_mux_pkg::mask_full : pin_mux_pkg::mask_pf_sel0_sm; // R7 R8
  localparam logic [7:0] mask_large =
    large_variant ? pin_mux_pkg::mask_full : pin_mux_pkg::mask_none; // R8

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    pin_mux_pkg::mux_state_t regs;
    logic [1:0]              pin1_sync;
    logic [1:0]              pin3_sync;
  } block_state_t;

  block_state_t            q;
  block_state_t            d;
  logic [1:0]              pin3_sel;
  logic [1:0]              pin1_sel;
  pin_mux_pkg::pin_drive_t pin3_drive;
  pin_mux_pkg::pin_drive_t pin1_drive;
  logic                    spi_in_sel;
  logic                    timer_in_sel;

  // ------------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------------
  // Register match on the byte address
  function automatic logic addr_hit(
    input logic [7:0] a,
    input logic [7:0] target
  );
    return a == target;
  endfunction

  // Keep only implemented bits
  function automatic logic [7:0] masked(
    input logic [7:0] data,
    input logic [7:0] mask
  );
    return data & mask;
  endfunction

  // Two-bit selection field at a given position
  function automatic logic [1:0] field_of(
    input logic [7:0] value,
    input int         lsb
  );
    return value[lsb +: 2];
  endfunction

  // Pin drive from a value and an enable
  function automatic pin_mux_pkg::pin_drive_t drive_of(
    input logic value,
    input logic enable
  );
    pin_mux_pkg::pin_drive_t result;
    result.value  = value;
    result.enable = enable;
    return result;
  endfunction

  // Power-on contents of every register
  function automatic pin_mux_pkg::mux_state_t reset_regs();
    pin_mux_pkg::mux_state_t result;
    result.threshold = pin_mux_pkg::reg_reset; // R2
    result.pa0       = pin_mux_pkg::reg_reset; // R13
    result.pa1       = pin_mux_pkg::reg_reset;
    result.pb0       = pin_mux_pkg::reg_reset;
    result.pb1       = pin_mux_pkg::reg_reset;
    result.pc0       = pin_mux_pkg::reg_reset;
    result.pd0       = pin_mux_pkg::reg_reset;
    result.pd1       = pin_mux_pkg::reg_reset;
    result.pe0       = pin_mux_pkg::reg_reset;
    result.pe1       = pin_mux_pkg::reg_reset;
    result.pf0       = pin_mux_pkg::reg_reset;
    result.pf1       = pin_mux_pkg::reg_reset;
    result.rdata     = pin_mux_pkg::reg_reset;
    return result;
  endfunction

  // Read mux over the register file
  function automatic logic [7:0] read_value(
    input logic [7:0]              a,
    input pin_mux_pkg::mux_state_t regs
  );
    logic [7:0] result;
    result = pin_mux_pkg::reg_reset;
    if (addr_hit(a, pin_mux_pkg::addr_threshold_sel))
    begin
      result = regs.threshold; // R2
    end
    else if (addr_hit(a, pin_mux_pkg::addr_pa_sel0))
    begin
      result = regs.pa0; // R13
    end
    else if (addr_hit(a, pin_mux_pkg::addr_pa_sel1))
    begin
      result = regs.pa1;
    end
    else if (addr_hit(a, pin_mux_pkg::addr_pb_sel0))
    begin
      result = regs.pb0;
    end
    else if (addr_hit(a, pin_mux_pkg::addr_pb_sel1))
    begin
      result = regs.pb1;
    end
    else if (addr_hit(a, pin_mux_pkg::addr_pc_sel0))
    begin
      result = regs.pc0;
    end
    else if (addr_hit(a, pin_mux_pkg::addr_pd_sel0))
    begin
      result = regs.pd0;
    end
    else if (addr_hit(a, pin_mux_pkg::addr_pd_sel1))
    begin
      result = regs.pd1;
    end
    else if (addr_hit(a, pin_mux_pkg::addr_pe_sel0))
    begin
      result = regs.pe0;
    end
    else if (addr_hit(a, pin_mux_pkg::addr_pe_sel1))
    begin
      result = regs.pe1;
    end
    else if (addr_hit(a, pin_mux_pkg::addr_pf_sel0))
    begin
      result = regs.pf0;
    end
    else if (addr_hit(a, pin_mux_pkg::addr_pf_sel1))
    begin
      result = regs.pf1;
    end
    else
    begin
      result = pin_mux_pkg::reg_reset; // R3
    end
    return result;
  endfunction

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb
  begin
    d           = q;
    d.pin1_sync = {q.pin1_sync[0], port_a_pin1_in};
    d.pin3_sync = {q.pin3_sync[0], port_a_pin3_in};
    if (wr_en)
    begin
      if (addr_hit(addr, pin_mux_pkg::addr_threshold_sel))
      begin
        d.regs.threshold = masked(wdata, pin_mux_pkg::mask_threshold); // R1 R2
      end
      else if (addr_hit(addr, pin_mux_pkg::addr_pa_sel0))
      begin
        d.regs.pa0 = masked(wdata, pin_mux_pkg::mask_pa_sel0); // R3 R13
      end
      else if (addr_hit(addr, pin_mux_pkg::addr_pa_sel1))
      begin
        d.regs.pa1 = masked(wdata, pin_mux_pkg::mask_full); // R7
      end
      else if (addr_hit(addr, pin_mux_pkg::addr_pb_sel0))
      begin
        d.regs.pb0 = masked(wdata, pin_mux_pkg::mask_full); // R7
      end
      else if (addr_hit(addr, pin_mux_pkg::addr_pb_sel1))
      begin
        d.regs.pb1 = masked(wdata, mask_pb1); // R7 R8
      end
      else if (addr_hit(addr, pin_mux_pkg::addr_pc_sel0))
      begin
        d.regs.pc0 = masked(wdata, pin_mux_pkg::mask_pc_sel0); // R7
      end
      else if (addr_hit(addr, pin_mux_pkg::addr_pd_sel0))
      begin
        d.regs.pd0 = masked(wdata, mask_large); // R8
      end
      else if (addr_hit(addr, pin_mux_pkg::addr_pd_sel1))
      begin
        d.regs.pd1 = masked(wdata, mask_large); // R8
      end
      else if (addr_hit(addr, pin_mux_pkg::addr_pe_sel0))
      begin
        d.regs.pe0 = masked(wdata, mask_large); // R8
      end
      else if (addr_hit(addr, pin_mux_pkg::addr_pe_sel1))
      begin
        d.regs.pe1 = masked(wdata, mask_large); // R8
      end
      else if (addr_hit(addr, pin_mux_pkg::addr_pf_sel0))
      begin
        d.regs.pf0 = masked(wdata, mask_pf0); // R7 R8
      end
      else if (addr_hit(addr, pin_mux_pkg::addr_pf_sel1))
      begin
        d.regs.pf1 = masked(wdata, mask_large); // R8
      end
    end
    if (rd_en)
    begin
      d.regs.rdata = read_value(addr, q.regs);
    end
    else
    begin
      d.regs.rdata = pin_mux_pkg::reg_reset;
    end
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      q.regs      <= reset_regs(); // R2 R13
      q.pin1_sync <= '0;
      q.pin3_sync <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  // ------------------------------------------------------------------
  // Pin function multiplexer
  // ------------------------------------------------------------------
  assign pin3_sel = field_of(q.regs.pa0, pin_mux_pkg::pin3_field_lsb); // R3
  assign pin1_sel = field_of(q.regs.pa0, pin_mux_pkg::pin1_field_lsb); // R3

  always_comb
  begin
    pin3_drive = gpio_pin3;
    spi_in_sel = 1'b0;
    if (large_variant)
    begin
      case (pin3_sel)
        pin_mux_pkg::code_gpio: pin3_drive = gpio_pin3; // R10
        pin_mux_pkg::code_alt1: pin3_drive = drive_of(freq_output_0, 1'b1); // R10 R14
        pin_mux_pkg::code_alt2:
        begin
          pin3_drive = drive_of(1'b0, 1'b0); // R10
          spi_in_sel = 1'b1; // R10
        end
        default: pin3_drive = key_row_16; // R10
      endcase
    end
    else
    begin
      case (pin3_sel)
        pin_mux_pkg::code_keyrow: pin3_drive = key_row_1; // R9
        default:                  pin3_drive = gpio_pin3; // R9
      endcase
    end
  end

  always_comb
  begin
    pin1_drive   = gpio_pin1;
    timer_in_sel = 1'b0;
    if (large_variant)
    begin
      case (pin1_sel)
        pin_mux_pkg::code_gpio,
        pin_mux_pkg::code_alt1:
        begin
          pin1_drive   = gpio_pin1; // R12
          timer_in_sel = 1'b1; // R12
        end
        pin_mux_pkg::code_alt2: pin1_drive = drive_of(spi_data_out_pin, 1'b1); // R12 R14
        default: pin1_drive = key_row_17; // R12
      endcase
    end
    else
    begin
      case (pin1_sel)
        pin_mux_pkg::code_keyrow: pin1_drive = key_row_0; // R11
        default:                  pin1_drive = gpio_pin1; // R11
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign port_a_pin3_out    = pin3_drive.value; // R14
  assign port_a_pin3_oe_n   = ~pin3_drive.enable; // R14
  assign port_a_pin1_out    = pin1_drive.value; // R14
  assign port_a_pin1_oe_n   = ~pin1_drive.enable; // R14
  assign periph_in          = {spi_in_sel & q.pin3_sync[1], timer_in_sel & q.pin1_sync[1]}; // R15
  assign port_d_upper_level = q.regs.threshold[pin_mux_pkg::upper_nibble_threshold_bit]; // R1
  assign port_d_lower_level = q.regs.threshold[pin_mux_pkg::lower_nibble_threshold_bit]; // R1
  assign rdata              = q.regs.rdata;

endmodule // pin_function_and_input_level_select
`default_nettype wire

// ---- pkg/pin_mux_pkg.sv ----
/*
 Register map, field positions and carrier types of the pin function
 and input threshold select block.
 Assumes an 8-bit register port with a byte address.
*/
`default_nettype none
package pin_mux_pkg;

  // ------------------------------------------------------------------
  // Register addresses
  // ------------------------------------------------------------------
  localparam logic [7:0] addr_threshold_sel = 8'h00;
  localparam logic [7:0] addr_pa_sel0       = 8'h01;
  localparam logic [7:0] addr_pa_sel1       = 8'h02;
  localparam logic [7:0] addr_pb_sel0       = 8'h03;
  localparam logic [7:0] addr_pb_sel1       = 8'h04;
  localparam logic [7:0] addr_pc_sel0       = 8'h05;
  localparam logic [7:0] addr_pd_sel0       = 8'h06;
  localparam logic [7:0] addr_pd_sel1       = 8'h07;
  localparam logic [7:0] addr_pe_sel0       = 8'h08;
  localparam logic [7:0] addr_pe_sel1       = 8'h09;
  localparam logic [7:0] addr_pf_sel0       = 8'h0a;
  localparam logic [7:0] addr_pf_sel1       = 8'h0b;

  // ------------------------------------------------------------------
  // Implemented bit masks and reset value
  // ------------------------------------------------------------------
  localparam logic [7:0] mask_threshold  = 8'h03;
  localparam logic [7:0] mask_pa_sel0    = 8'hcc;
  localparam logic [7:0] mask_full       = 8'hff;
  localparam logic [7:0] mask_pb_sel1_sm = 8'h0f;
  localparam logic [7:0] mask_pb_sel1_lg = 8'h3f;
  localparam logic [7:0] mask_pc_sel0    = 8'h03;
  localparam logic [7:0] mask_pf_sel0_sm = 8'h3f;
  localparam logic [7:0] mask_none       = 8'h00;
  localparam logic [7:0] reg_reset       = 8'h00;

  // Field positions
  localparam int upper_nibble_threshold_bit = 1;
  localparam int lower_nibble_threshold_bit = 0;
  localparam int pin3_field_lsb = 6;
  localparam int pin1_field_lsb = 2;

  // Field codes
  localparam logic [1:0] code_gpio   = 2'h0;
  localparam logic [1:0] code_alt1   = 2'h1;
  localparam logic [1:0] code_alt2   = 2'h2;
  localparam logic [1:0] code_keyrow = 2'h3;

  // ------------------------------------------------------------------
  // Carrier types
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] threshold;
    logic [7:0] pa0;
    logic [7:0] pa1;
    logic [7:0] pb0;
    logic [7:0] pb1;
    logic [7:0] pc0;
    logic [7:0] pd0;
    logic [7:0] pd1;
    logic [7:0] pe0;
    logic [7:0] pe1;
    logic [7:0] pf0;
    logic [7:0] pf1;
    logic [7:0] rdata;
  } mux_state_t;

  // Output value and enable of one pin
  typedef struct packed {
    logic value;
    logic enable;
  } pin_drive_t;

  // Peripheral inputs taken from the pins
  typedef struct packed {
    logic spi_data_in_pin;
    logic timer0_clock_input;
  } periph_in_t;

endpackage
`default_nettype wire

// ---- tb/pin_mux_checker.sv ----
/* Port checks of the pin select block.
 Bound by name into the top module. */
`timescale 1ns/1ps
`default_nettype none
module pin_mux_checker (input wire logic clk, reset, wr_en, rd_en, freq_output_0,
  port_a_pin3_out, port_a_pin3_oe_n, port_d_upper_level, port_d_lower_level,
  input wire logic [7:0] addr, wdata, rdata);
  logic [1:0] c_q;
  always_ff @(posedge clk) if (reset) c_q <= 2'h0;
    else if (wr_en && addr == 8'h01) c_q <= wdata[7:6];
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_w; wr_en && addr == 8'h00; endsequence
  sequence s_r(a); rd_en && addr == a; endsequence
  property p_up; s_w |=> port_d_upper_level == $past(wdata[1]); endproperty
  a_up: assert property (p_up) else $error("upper level");
  property p_lo; s_w |=> port_d_lower_level == $past(wdata[0]); endproperty
  a_lo: assert property (p_lo) else $error("lower level");
  property p_rb; s_w ##1 s_r(8'h00) |=> rdata == ($past(wdata, 2) & 8'h03); endproperty
  a_rb: assert property (p_rb) else $error("level readback");
  property p_rz; s_r(8'h00) |=> rdata[7:2] == 6'h00; endproperty
  a_rz: assert property (p_rz) else $error("level high bits");
  property p_pa; s_r(8'h01) |=> (rdata & 8'h33) == 8'h00; endproperty
  a_pa: assert property (p_pa) else $error("select holes");
  property p_fq; c_q == 2'h1 |-> port_a_pin3_out == freq_output_0 && !port_a_pin3_oe_n; endproperty
  a_fq: assert property (p_fq) else $error("freq route");
  property p_si; c_q == 2'h2 |-> port_a_pin3_oe_n; endproperty
  a_si: assert property (p_si) else $error("spi in drives");
  property p_rs; $fell(reset) |-> !port_d_upper_level && !port_d_lower_level; endproperty
  a_rs: assert property (p_rs) else $error("level reset");
endmodule // pin_mux_checker
`default_nettype wire

// ---- tb/pin_peer_model.sv ----
/* Peripherals and pins beside port A pins 1 and 3.
 Levels follow a word that the bench steps. */
`timescale 1ns/1ps
`default_nettype none
module pin_peer_model (input wire logic [11:0] s,
  output var pin_mux_pkg::pin_drive_t g1, g3, k16, k17, output var logic fo, so, p1, p3);
  assign {g1, g3, k16, k17, fo, so, p1, p3} = s;
endmodule // pin_peer_model
`default_nettype wire

// ---- tb/tb_pin_function_and_input_level_select.sv ----
/* Bench of the pin select block and its peer model.
 Checker bound at the foot. */
`timescale 1ns/1ps
`default_nettype none
module tb_pin_function_and_input_level_select;
  logic clk = 0, reset = 1, wr_en = 0, rd_en = 0, freq_output_0, spi_data_out_pin;
  logic port_a_pin1_in, port_a_pin3_in, port_a_pin1_out, port_a_pin1_oe_n, port_a_pin3_out;
  logic port_a_pin3_oe_n, port_d_upper_level, port_d_lower_level;
  logic [7:0] addr = 0, wdata = 0, rdata, rv;
  logic [15:0] r;
  logic [31:0] rs = 32'h0164;
  int n_mismatch = 0, checks_done = 0, cyc = 0;
  pin_mux_pkg::pin_drive_t gpio_pin1, gpio_pin3, key_row_16, key_row_17, key_row_0 = 0, key_row_1 = 0;
  pin_mux_pkg::periph_in_t periph_in;
  always #20 clk = ~clk;
  pin_peer_model u_pin_peer_model (.s(rs[11:0]), .g1(gpio_pin1), .g3(gpio_pin3), .k16(key_row_16),
    .k17(key_row_17), .fo(freq_output_0), .so(spi_data_out_pin), .p1(port_a_pin1_in), .p3(port_a_pin3_in));
  pin_function_and_input_level_select u_pin_function_and_input_level_select (.*);
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13; x ^= x >> 17; return x ^ (x << 5);
  endfunction
  function automatic logic [1:0] dr(input pin_mux_pkg::pin_drive_t p); return {p.value, ~p.enable}; endfunction
  function automatic logic [7:0] ex(input logic [1:0] a, b);
    return {2'h0, a == 0 ? dr(gpio_pin3) : a == 1 ? {freq_output_0, 1'b0} : a == 2 ? {1'b0, 1'b1}
      : dr(key_row_16), b < 2 ? dr(gpio_pin1) : b == 2 ? {spi_data_out_pin, 1'b0} : dr(key_row_17),
      a == 2 && port_a_pin3_in, b < 2 && port_a_pin1_in};
  endfunction
  task automatic chk(input string n, input logic [7:0] s, e);
    checks_done++;
    if (s !== e) begin n_mismatch++; $display("ERROR %s exp %h seen %h", n, e, s); end
  endtask
  task automatic wr(input logic [7:0] a, d);
    addr <= a; wdata <= d; wr_en <= 1; @(posedge clk); wr_en <= 0;
  endtask
  task automatic rd(input logic [7:0] a);
    addr <= a; rd_en <= 1; @(posedge clk); rd_en <= 0; #1 rv = rdata; @(posedge clk);
  endtask
  task automatic summarize;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk) if (++cyc > 3000) begin n_mismatch++; summarize(); end
  initial begin
    repeat (8) @(posedge clk);
    reset <= 0;
    rd(8'h00); chk("level reg", rv, 8'h00);
    rd(8'h01); chk("pa select", rv, 8'h00);
    rd(8'h20); chk("unmapped", rv, 8'h00);
    wr(8'h04, 8'hff); rd(8'h04); chk("pb select 1", rv, 8'h3f);
    for (int i = 0; i < 40; i++) begin
      r = rs[27:12];
      wr(8'h00, r[7:0]); rd(8'h00); chk("level reg", rv, r[7:0] & 8'h03);
      chk("levels", {6'h0, port_d_upper_level, port_d_lower_level}, {6'h0, r[1:0]});
      wr(8'h01, r[15:8]); rd(8'h01); chk("pa select", rv, r[15:8] & 8'hcc);
      rs <= xs(rs);
      repeat (4) @(posedge clk);
      #1 chk("pins", {2'h0, port_a_pin3_out, port_a_pin3_oe_n, port_a_pin1_out, port_a_pin1_oe_n,
        periph_in}, ex(r[15:14], r[11:10]));
      @(posedge clk);
    end
    summarize();
  end
endmodule // tb_pin_function_and_input_level_select
bind pin_function_and_input_level_select pin_mux_checker u_pin_mux_checker (.*);
`default_nettype wire
